/* File: ecpd_periph_model.sv */
// peripheral model: forward handshake and reverse data drive
`timescale 1ns/1ps
module ecpd_periph_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host side pins
    input wire logic [7:0] pd_out,
    input wire logic nstrobe,
    input wire logic nautofd,
    input wire logic nselectin,
    input wire logic ninit,
    input wire logic ecp_mode,
    input wire logic slow,
    // peripheral pins and capture log
    output logic busy,
    output logic drv_en,
    output logic [7:0] drv_data,
    output logic [7:0] last_byte,
    output logic last_tag_n,
    output int n_bytes
);
    int wait_cnt;
    // ------------------------------------------------------------
    // reverse drive only when every qualifier allows it
    // ------------------------------------------------------------
    assign drv_en = ecp_mode && !ninit && !nautofd
        && nselectin;
    assign drv_data = 8'h96;
    // ------------------------------------------------------------
    // busy answers a strobe after two or seven cycles
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            wait_cnt <= 0;
            n_bytes <= 0;
            last_byte <= 8'h00;
            last_tag_n <= 1'b1;
        end else if (!busy && !nstrobe) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= (slow ? 6 : 1)) begin
                busy <= 1'b1;
                wait_cnt <= 0;
                last_byte <= pd_out;
                last_tag_n <= nautofd;
                n_bytes <= n_bytes + 1;
            end
        end else if (busy && nstrobe) begin
            busy <= 1'b0;
        end
    end
endmodule // ecpd_periph_model

/* File: ecpd_pkg.sv */
// constants for the ecp port register decode block
//
// Contract
// - in ecp mode ninit goes low for reverse, high for forward
// - nselectin stays deasserted whenever the port is in ecp mode
// - offsets 0, 400h and 401h decode according to the current mode field
// - mode field is bits 7 to 5 of extended control, read and write
// - extra registers decode at base plus 400h to 402h
// - offsets are added to a configurable base before comparison
// - every decode is qualified by address enable being low
// - mode codes: spp, bidir, compat, ecp, epp, reserved, test, configuration
// - offset 400h: compat, ecp data, test queue or capability word a
// - mode 100 means epp only when epp support is enabled
// - data latch at offset 0 in modes 000 and 001, reset to zero
// - host write to the data latch stores the bus byte
// - data latch drives the data pins without inversion
// - data port read returns the pin levels, not the latch
// - mode 011 write at offset 0 queues a byte tagged as address
// - tagged bytes go out by the handshake engine on their own
// - status at offset 1 in all modes, bits 2 to 0 read zero
package ecpd_pkg;
    // ------------------------------------------------------------
    // register offsets from the port base
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_DATA = 16'h0000;
    localparam logic [15:0] OFF_STATUS = 16'h0001;
    localparam logic [15:0] OFF_CTRL = 16'h0002;
    localparam logic [15:0] OFF_QUEUE = 16'h0400;
    localparam logic [15:0] OFF_CFG_B = 16'h0401;
    localparam logic [15:0] OFF_ECR = 16'h0402;
    // ------------------------------------------------------------
    // mode field codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_SPP = 3'h0;
    localparam logic [2:0] MODE_BIDIR = 3'h1;
    localparam logic [2:0] MODE_COMPAT = 3'h2;
    localparam logic [2:0] MODE_ECP = 3'h3;
    localparam logic [2:0] MODE_EPP = 3'h4;
    localparam logic [2:0] MODE_RSVD = 3'h5;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CFG = 3'h7;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ECR_MODE_HI = 7;
    localparam int ECR_MODE_LO = 5;
    localparam int ECR_CTL_HI = 4;
    localparam int ECR_CTL_LO = 2;
    localparam int CTRL_STROBE = 0;
    localparam int CTRL_AUTOFD = 1;
    localparam int CTRL_INIT = 2;
    localparam int CTRL_SELIN = 3;
    localparam int CTRL_DIR = 5;
    localparam int CTRL_W = 6;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [2:0] ECR_MODE_RESET = 3'h0;
    localparam logic [2:0] ECR_CTL_RESET = 3'h0;
    localparam logic [7:0] CFG_A_VALUE = 8'h10;
    localparam logic [2:0] STATUS_LOW_ZERO = 3'h0;
    // queue entry: tag bit above the byte, set for address bytes
    localparam int QW = 9;
    localparam int TAG_BIT = 8;
endpackage

/* File: ecpd_queue.sv */
// tagged byte queue with registered read data
`timescale 1ns/1ps
module ecpd_queue
    import ecpd_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // queue port
    ecpd_queue_if.store q
);
    logic [QW-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] fill;
    logic do_push;
    logic do_pop;

    assign fill = wr_ptr - rd_ptr;
    assign q.full = (fill == (AW+1)'(DEPTH));
    assign q.empty = (fill == '0);
    // a full queue drops the write; an empty one keeps the last byte
    assign do_push = q.push && !q.full;
    assign do_pop = q.pop && !q.empty;

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= q.push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q.rd_data <= '0;
        end else if (do_pop) begin
            q.rd_data <= mem[rd_ptr[AW-1:0]];
        end
    end
endmodule // ecpd_queue

/* File: ecpd_queue_if.sv */
// interface between the decode logic and the byte queue
`timescale 1ns/1ps
interface ecpd_queue_if;
    logic push;
    logic [8:0] push_data;
    logic pop;
    logic [8:0] rd_data;
    logic full;
    logic empty;
    modport store (input push, push_data, pop, output rd_data, full, empty);
    modport user (output push, push_data, pop, input rd_data, full, empty);
endinterface

/* File: ecpd_top.sv */
// ecp parallel port register decode, data port and forward queue
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module ecpd_top
    import ecpd_pkg::*;
#(
    parameter int QUEUE_DEPTH = 16,
    parameter int QUEUE_AW = 4,
    parameter logic [2:0] CFG_B_IRQ = 3'h0,
    parameter logic [2:0] CFG_B_DMA = 3'h0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host register port
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_aen,
    output logic [7:0] bus_rdata,
    // configuration
    input wire logic [15:0] base_addr,
    input wire logic epp_enable,
    // parallel data pins
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic pd_oe,
    // peripheral status pins
    input wire logic busy_in,
    input wire logic nack_in,
    input wire logic perror_in,
    input wire logic select_in,
    input wire logic nfault_in,
    // control pins
    output logic nstrobe_out,
    output logic nautofd_out,
    output logic ninit_out,
    output logic nselectin_out
);
    // ------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_RELEASE = 4'b1000
    } ecpd_state_e;

    // epp code falls back to spp unless epp support is on
    function automatic logic [2:0] effective_mode(input logic [2:0] m,
                                                   input logic epp_on);
        if (m == MODE_EPP && !epp_on) begin
            return MODE_SPP;
        end
        return m;
    endfunction

    // direction bit has no effect in the output-only modes
    function automatic logic forward_only(input logic [2:0] m);
        return (m == MODE_SPP) || (m == MODE_COMPAT);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [12:0] pin_meta;
    logic [12:0] pin_sync;
    logic [7:0] pd_sync;
    logic busy_s;
    logic nack_s;
    logic perror_s;
    logic select_s;
    logic nfault_s;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {nfault_in, select_in, perror_in, nack_in, busy_in,
                         pd_in};
            pin_sync <= pin_meta;
        end
    end

    assign pd_sync = pin_sync[7:0];
    assign busy_s = pin_sync[8];
    assign nack_s = pin_sync[9];
    assign perror_s = pin_sync[10];
    assign select_s = pin_sync[11];
    assign nfault_s = pin_sync[12];

    // ------------------------------------------------------------
    // registers and queue
    // ------------------------------------------------------------
    logic [7:0] data_latch;
    logic [CTRL_W-1:0] ctrl;
    logic [2:0] ecr_mode;
    logic [2:0] ecr_ctl;
    logic [2:0] mode;
    logic dir_eff;
    logic [15:0] off;
    logic sel_data, sel_addrq, sel_status, sel_ctrl;
    logic sel_fifo, sel_cfga, sel_cfgb, sel_ecr;
    logic host_pop;
    logic eng_pop;
    logic drain_en;
    logic [7:0] rd_value;
    logic [7:0] rdata_reg;
    logic rd_from_q;
    ecpd_state_e state;
    ecpd_state_e next_state;
    logic [7:0] out_byte;
    logic out_tag;

    ecpd_queue_if q_if();

    ecpd_queue #(
        .DEPTH(QUEUE_DEPTH),
        .AW(QUEUE_AW)
    ) u_queue (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .q(q_if)
    );

    assign mode = effective_mode(ecr_mode, epp_enable);
    assign dir_eff = ctrl[CTRL_DIR] && !forward_only(mode);
    assign off = bus_addr - base_addr;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        sel_data = 1'b0;
        sel_addrq = 1'b0;
        sel_status = 1'b0;
        sel_ctrl = 1'b0;
        sel_fifo = 1'b0;
        sel_cfga = 1'b0;
        sel_cfgb = 1'b0;
        sel_ecr = 1'b0;
        // dma address cycles must never hit a register
        if (bus_aen) begin
            sel_data = 1'b0;
        end else if (off == OFF_DATA) begin
            sel_data = (mode == MODE_SPP)
                || (mode == MODE_BIDIR);
            sel_addrq = (mode == MODE_ECP);
        end else if (off == OFF_STATUS) begin
            sel_status = 1'b1;
        end else if (off == OFF_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (off == OFF_QUEUE) begin
            sel_fifo = (mode == MODE_COMPAT) || (mode == MODE_ECP)
                || (mode == MODE_TEST);
            sel_cfga = (mode == MODE_CFG);
        end else if (off == OFF_CFG_B) begin
            sel_cfgb = (mode == MODE_CFG);
        end else if (off == OFF_ECR) begin
            sel_ecr = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_latch <= DATA_RESET;
        end else if (bus_wr && sel_data) begin
            data_latch <= bus_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (bus_wr && sel_ctrl) begin
            ctrl <= bus_wdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ecr_mode <= ECR_MODE_RESET;
            ecr_ctl <= ECR_CTL_RESET;
        end else if (bus_wr && sel_ecr) begin
            ecr_mode <= bus_wdata[ECR_MODE_HI:ECR_MODE_LO];
            ecr_ctl <= bus_wdata[ECR_CTL_HI:ECR_CTL_LO];
        end
    end

    // address bytes carry the tag; reverse writes outside test mode are simply dropped
    assign q_if.push = bus_wr && ((sel_addrq && !dir_eff)
        || (sel_fifo && (mode == MODE_TEST || !dir_eff)));
    assign q_if.push_data = {sel_addrq, bus_wdata};
    assign host_pop = bus_rd && sel_fifo && (mode == MODE_TEST || dir_eff);
    assign q_if.pop = host_pop || eng_pop;

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        rd_value = 8'h00;
        if (sel_data) begin
            rd_value = pd_sync;
        end else if (sel_status) begin
            rd_value = {~busy_s, nack_s, perror_s, select_s, nfault_s,
                        STATUS_LOW_ZERO};
        end else if (sel_ctrl) begin
            rd_value = {2'h0, ctrl};
        end else if (sel_cfga) begin
            rd_value = CFG_A_VALUE;
        end else if (sel_cfgb) begin
            rd_value = {2'h0, CFG_B_IRQ, CFG_B_DMA};
        end else if (sel_ecr) begin
            rd_value = {ecr_mode, ecr_ctl, q_if.full, q_if.empty};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            rd_from_q <= 1'b0;
        end else begin
            rdata_reg <= bus_rd ? rd_value : 8'h00;
            rd_from_q <= bus_rd && sel_fifo;
        end
    end

    // queue read data is already a register, one cycle after the pop
    assign bus_rdata = rd_from_q ? q_if.rd_data[7:0] : rdata_reg;

    // ------------------------------------------------------------
    // forward handshake engine
    // ------------------------------------------------------------
    assign drain_en = !dir_eff && (mode == MODE_ECP || mode == MODE_COMPAT);
    assign eng_pop = (state == ST_IDLE) && drain_en
        && !q_if.empty;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (eng_pop) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (busy_s) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!busy_s) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_byte <= 8'h00;
            out_tag <= 1'b0;
        end else if (state == ST_LOAD) begin
            out_byte <= q_if.rd_data[7:0];
            out_tag <= q_if.rd_data[TAG_BIT];
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_out <= 8'h00;
            pd_oe <= 1'b1;
        end else begin
            // byte must already stand on the pins when the strobe falls
            pd_out <= (state == ST_LOAD) ? q_if.rd_data[7:0]
                : (state == ST_IDLE) ? data_latch : out_byte;
            // release the bus in reverse so the peripheral may drive it
            pd_oe <= !dir_eff;
        end
    end

    assign nstrobe_out = (state == ST_STROBE) ? 1'b0 : ~ctrl[CTRL_STROBE];
    // host ack low marks a command byte while the engine runs
    assign nautofd_out = (mode == MODE_ECP && state != ST_IDLE) ? ~out_tag
        : ~ctrl[CTRL_AUTOFD];
    assign ninit_out = (mode == MODE_ECP) ? ~ctrl[CTRL_DIR]
        : ctrl[CTRL_INIT];
    assign nselectin_out = (mode == MODE_ECP) ? 1'b1
        : ~ctrl[CTRL_SELIN];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_nselectin;
        @(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_ECP) |-> nselectin_out;
    endproperty
    a_nselectin: assert property (p_nselectin)
        else $error("nselectin asserted in ecp mode");

    property p_ninit_dir;
        @(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_ECP) |-> (ninit_out == !ctrl[CTRL_DIR]);
    endproperty
    a_ninit_dir: assert property (p_ninit_dir)
        else $error("ninit does not follow direction in ecp mode");

    property p_status_low;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_rd && sel_status) |=> (bus_rdata[2:0] == 3'h0);
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("status low bits not zero");

    property p_data_to_pins;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_wr && sel_data && state == ST_IDLE)
            ##1 (state == ST_IDLE) |=> (pd_out == $past(bus_wdata, 2));
    endproperty
    a_data_to_pins: assert property (p_data_to_pins)
        else $error("written data byte not on data pins");

    property p_aen_block;
        @(posedge clk_sys) disable iff (!rst_n)
        bus_aen |=> $stable(data_latch) && $stable(ctrl) && $stable(ecr_mode);
    endproperty
    a_aen_block: assert property (p_aen_block)
        else $error("register changed during aen cycle");

    property p_read_pins;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_rd && sel_data) |=> (bus_rdata == $past(pd_sync));
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("data port read not the pin levels");

    property p_unmapped;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_rd && !(sel_data || sel_status || sel_ctrl || sel_fifo
            || sel_cfga || sel_cfgb || sel_ecr)) |=> (bus_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_addr_tag;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_wr && !bus_aen && off == OFF_DATA && mode == MODE_ECP
            && !dir_eff) |-> (q_if.push && q_if.push_data[TAG_BIT]);
    endproperty
    a_addr_tag: assert property (p_addr_tag)
        else $error("address byte not queued with tag");

    property p_mode_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_wr && sel_ecr) |=> (ecr_mode == $past(bus_wdata[7:5]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode field not written");

    property p_engine_start;
        @(posedge clk_sys) disable iff (!rst_n)
        eng_pop |-> ##2 (state == ST_STROBE && !nstrobe_out);
    endproperty
    a_engine_start: assert property (p_engine_start)
        else $error("queued byte not strobed out");

    property p_epp_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        !epp_enable |-> (mode != MODE_EPP);
    endproperty
    a_epp_gate: assert property (p_epp_gate)
        else $error("epp mode active while disabled");

    property p_cfg_a;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_rd && sel_cfga) |=> (bus_rdata == 8'h10);
    endproperty
    a_cfg_a: assert property (p_cfg_a)
        else $error("capability word a wrong");
endmodule // ecpd_top

/* File: testbench.sv */
// self-checking bench for the ecp port register decode block
`timescale 1ns/1ps
module testbench
    import ecpd_pkg::*;
;
    logic clk_sys, rst_n, bus_wr, bus_rd, bus_aen, slow, ecp_mode, epp_en;
    logic [15:0] bus_addr, base_addr;
    logic [7:0] bus_wdata, bus_rdata, pd_out, pd_in, drv_data, last_byte;
    logic nack_in, perror_in, select_in, nfault_in, pd_oe, busy_in, drv_en;
    logic nstrobe_out, nautofd_out, ninit_out, nselectin_out, last_tag_n;
    int fail_count, n_checks, n_bytes;
    // released lines show the peripheral byte when it drives, else the inverse, never the stale latch
    assign pd_in = pd_oe ? pd_out : (drv_en ? drv_data : ~pd_out);
    ecpd_top #(.QUEUE_DEPTH(4), .QUEUE_AW(2)) DUT (.clk_sys(clk_sys),
        .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_aen(bus_aen),
        .bus_rdata(bus_rdata), .base_addr(base_addr), .epp_enable(epp_en),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .busy_in(busy_in),
        .nack_in(nack_in), .perror_in(perror_in), .select_in(select_in),
        .nfault_in(nfault_in), .nstrobe_out(nstrobe_out),
        .nautofd_out(nautofd_out), .ninit_out(ninit_out),
        .nselectin_out(nselectin_out));
    ecpd_periph_model PERIPH (.clk_sys(clk_sys), .rst_n(rst_n),
        .pd_out(pd_out), .nstrobe(nstrobe_out), .nautofd(nautofd_out),
        .nselectin(nselectin_out), .ninit(ninit_out), .ecp_mode(ecp_mode),
        .slow(slow), .busy(busy_in), .drv_en(drv_en), .drv_data(drv_data),
        .last_byte(last_byte), .last_tag_n(last_tag_n), .n_bytes(n_bytes));
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] off, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= base_addr + off;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] off, input logic [7:0] e,
                      input string nm);
        @(posedge clk_sys);
        bus_addr <= base_addr + off;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(nm, e, bus_rdata);
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic set_mode(input logic [2:0] m, input logic [7:0] dcr);
        wr(OFF_ECR, {m, 5'h00});
        wr(OFF_CTRL, dcr);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // bounded wait for the peripheral to take a byte
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 300 && n_bytes < n; i++) @(posedge clk_sys);
        #1;
        if (n_bytes < n) begin
            fail_count++;
            summarize();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("pd_out", 8'h00, pd_out);
        chk("pd_oe", 8'h01, {7'h00, pd_oe});
        chk("nselectin", 8'h01, {7'h00, nselectin_out});
        rd(OFF_ECR, 8'h01, "ecr reset");
    endtask
    task automatic t_data();
        wr(OFF_DATA, 8'ha5);
        wait_cycles(2);
        chk("pd_out", 8'ha5, pd_out);
        @(posedge clk_sys);
        bus_aen <= 1'b1;
        wr(OFF_DATA, 8'h3c);
        rd(OFF_DATA, 8'h00, "aen read");
        @(posedge clk_sys);
        bus_aen <= 1'b0;
        wait_cycles(3);
        chk("pd_out aen", 8'ha5, pd_out);
        rd(16'h0003, 8'h00, "unmapped");
        set_mode(MODE_BIDIR, 8'h20);
        wait_cycles(4);
        rd(OFF_DATA, 8'h5a, "pin levels");
        set_mode(MODE_SPP, 8'h00);
    endtask
    task automatic t_status();
        @(posedge clk_sys);
        {nack_in, perror_in, select_in, nfault_in} <= 4'h5;
        wait_cycles(3);
        rd(OFF_STATUS, 8'ha8, "status a");
        wr(OFF_ECR, {MODE_CFG, 5'h00});
        {nack_in, perror_in, select_in, nfault_in} <= 4'ha;
        wait_cycles(3);
        rd(OFF_STATUS, 8'hd0, "status b");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            wr(OFF_ECR, {m[2:0], 5'h14});
            rd(OFF_ECR, {m[2:0], 5'h15}, "ecr mode");
        end
        wr(OFF_QUEUE, 8'hff);
        rd(OFF_QUEUE, 8'h10, "cfg a");
        rd(OFF_CFG_B, 8'h00, "cfg b");
        wr(OFF_ECR, {MODE_SPP, 5'h00});
        rd(OFF_QUEUE, 8'h00, "no queue");
        wr(OFF_ECR, {MODE_EPP, 5'h00});
        wr(OFF_DATA, 8'h69);
        wait_cycles(2);
        chk("epp off", 8'h69, pd_out);
        // with epp on, offset 0 is no longer the data latch
        @(posedge clk_sys);
        epp_en <= 1'b1;
        wr(OFF_DATA, 8'h17);
        wait_cycles(2);
        chk("epp on", 8'h69, pd_out);
        @(posedge clk_sys);
        epp_en <= 1'b0;
    endtask
    task automatic t_loopback_test_queue();
        logic [7:0] tq [5];
        tq = '{8'h44, 8'h33, 8'h22, 8'h11, 8'h99};
        wr(OFF_ECR, {MODE_TEST, 5'h00});
        for (int i = 0; i < 5; i++) wr(OFF_QUEUE, tq[i]);
        rd(OFF_ECR, 8'hc2, "full");
        for (int i = 0; i < 4; i++) begin
            rd(OFF_QUEUE, tq[i], "test queue");
        end
        rd(OFF_QUEUE, 8'h11, "underrun");
        rd(OFF_ECR, 8'hc1, "empty");
    endtask
    task automatic t_ecp();
        ecp_mode <= 1'b1;
        set_mode(MODE_ECP, 8'h08);
        wait_cycles(2);
        chk("nselectin", 8'h01, {7'h00, nselectin_out});
        chk("ninit fwd", 8'h01, {7'h00, ninit_out});
        wr(OFF_DATA, 8'h5a);
        wait_bytes(1);
        chk("addr byte", 8'h5a, last_byte);
        chk("addr tag", 8'h00, {7'h00, last_tag_n});
        slow <= 1'b1;
        wr(OFF_QUEUE, 8'hc3);
        wait_bytes(2);
        chk("data byte", 8'hc3, last_byte);
        chk("data tag", 8'h01, {7'h00, last_tag_n});
        wr(OFF_CTRL, 8'h2a);
        wait_cycles(2);
        chk("ninit rev", 8'h00, {7'h00, ninit_out});
        chk("nselectin rev", 8'h01, {7'h00, nselectin_out});
        chk("pd_oe rev", 8'h00, {7'h00, pd_oe});
    endtask
    // ------------------------------------------------------------
    // clock, reset and main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, bus_wr, bus_rd, bus_aen, slow, ecp_mode, epp_en} = 7'h00;
        {bus_addr, bus_wdata} = 24'h000000;
        base_addr = 16'h0378;
        {nack_in, perror_in, select_in, nfault_in} = 4'h0;
        fail_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_cycles(1);
        t_reset();
        t_data();
        t_status();
        t_modes();
        t_loopback_test_queue();
        t_ecp();
        summarize();
    end
endmodule // testbench
